// File: pkg/lucal_pkg.sv
// Package for the line unit control and alarm logic.
// Assumes a single 100 MHz system clock and APB register access.
package lucal_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CLK_MHZ = 100;

  // Drive monitor: 128 +/- 32 transmit clock periods
  localparam int unsigned DRV_MON_NOM = 128;
  localparam int unsigned DRV_MON_TOL = 32;
  localparam int unsigned DRV_MON_LIMIT = DRV_MON_NOM;
  localparam int unsigned DRV_CNT_W = 8;

  // Lock monitor: deviation limit 0.5 percent over a window of ref edges
  localparam int unsigned LOCK_WIN = 1024;
  localparam int unsigned LOCK_PERMIL = 5;
  localparam int unsigned LOCK_TOL = (LOCK_WIN * LOCK_PERMIL) / 1000;
  localparam int unsigned LOCK_CNT_W = 12;

  // Signal loss: zero-run lengths in received clock periods
  localparam int unsigned LOS_E3_RUN = 32;
  localparam int unsigned LOS_DS3_RUN_LO = 175;
  localparam int unsigned LOS_DS3_RUN_HI = 100;
  localparam int unsigned LOS_CNT_W = 8;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  // Control register fields (per channel bit 0..2)
  localparam int unsigned CTRL_E3_LSB = 0;
  localparam int unsigned CTRL_RST_VAL = 0;

  // Status / interrupt layout: per channel 4 bits
  localparam int unsigned EV_DRV = 0;
  localparam int unsigned EV_LOS = 1;
  localparam int unsigned EV_LOL = 2;
  localparam int unsigned EV_CV = 3;
  localparam int unsigned EV_PER_CH = 4;
  localparam int unsigned EV_W = NUM_CH * EV_PER_CH;

  typedef enum logic [1:0] {
    LUCAL_LOOP_NONE,
    LUCAL_LOOP_ANALOG_LOCAL,
    LUCAL_LOOP_REMOTE,
    LUCAL_LOOP_DIGITAL_LOCAL
  } lucal_loop_t;

  typedef struct packed {
    logic drive_fail_flag;
    logic rx_signal_loss_flag;
    logic rx_lock_loss_flag;
    logic code_violation_pulse;
  } lucal_alarm_t;
endpackage

// File: design/lucal_drv_mon.sv
// Per-channel drive monitor: counts transmit clock ticks without a mark.
// Assumes tx_tick_i is a one-cycle pulse per transmit clock period.
`timescale 1ns/1ns
module lucal_drv_mon (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic tx_tick_i,
  input wire logic monitor_tip_in_i,
  input wire logic monitor_ring_in_i,
  output logic drive_fail_flag_o
);
  logic [lucal_pkg::DRV_CNT_W-1:0] idle_cnt;
  wire mark_seen = monitor_tip_in_i ^ monitor_ring_in_i;
  wire limit_hit = idle_cnt ==
    lucal_pkg::DRV_CNT_W'(lucal_pkg::DRV_MON_LIMIT - 1);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || mark_seen) begin
      idle_cnt <= '0;
      drive_fail_flag_o <= 1'b0;
    end else if (tx_tick_i) begin
      if (limit_hit)
        drive_fail_flag_o <= 1'b1;
      else
        idle_cnt <= idle_cnt + 1'b1;
    end
  end
endmodule // lucal_drv_mon

// File: design/lucal_rx_mon.sv
// Per-channel receive monitor: signal loss, lock loss, violation pulse.
// Assumes rx_tick_i and ref_tick_i are one-cycle clock-edge pulses.
`timescale 1ns/1ns
module lucal_rx_mon (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic rx_tick_i,
  input wire logic ref_tick_i,
  input wire logic rx_mark_i,
  input wire logic code_err_i,
  input wire logic e3_mode_i,
  input wire logic threshold_sel_i,
  output logic signal_loss_o,
  output logic lock_loss_o,
  output logic violation_o
);
  logic [lucal_pkg::LOS_CNT_W-1:0] zero_cnt;
  logic [lucal_pkg::LOCK_CNT_W-1:0] ref_cnt;
  logic [lucal_pkg::LOCK_CNT_W-1:0] rx_cnt;
  logic [lucal_pkg::LOS_CNT_W-1:0] los_limit;

  // Threshold only in DS3 or STS-1
  assign los_limit = e3_mode_i ?
    lucal_pkg::LOS_CNT_W'(lucal_pkg::LOS_E3_RUN) :
    (threshold_sel_i ? lucal_pkg::LOS_CNT_W'(lucal_pkg::LOS_DS3_RUN_HI) :
      lucal_pkg::LOS_CNT_W'(lucal_pkg::LOS_DS3_RUN_LO));

  wire win_end = ref_tick_i && (ref_cnt ==
    lucal_pkg::LOCK_CNT_W'(lucal_pkg::LOCK_WIN - 1));
  wire too_low = rx_cnt <
    lucal_pkg::LOCK_CNT_W'(lucal_pkg::LOCK_WIN - lucal_pkg::LOCK_TOL);
  wire too_high = rx_cnt >
    lucal_pkg::LOCK_CNT_W'(lucal_pkg::LOCK_WIN + lucal_pkg::LOCK_TOL);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || rx_mark_i) begin
      zero_cnt <= '0;
      signal_loss_o <= 1'b0;
    end else if (rx_tick_i) begin
      if (zero_cnt >= los_limit)
        signal_loss_o <= 1'b1;
      else
        zero_cnt <= zero_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ref_cnt <= '0;
      rx_cnt <= '0;
      lock_loss_o <= 1'b0;
    end else if (win_end) begin
      ref_cnt <= '0;
      rx_cnt <= '0;
      lock_loss_o <= too_low || too_high;
    end else begin
      if (ref_tick_i)
        ref_cnt <= ref_cnt + 1'b1;
      if (rx_tick_i && rx_cnt != '1)
        rx_cnt <= rx_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      violation_o <= 1'b0;
    else
      violation_o <= code_err_i && rx_tick_i;
  end
endmodule // lucal_rx_mon

// File: design/lucal_top.sv
// Control and alarm logic for three line channels with an APB slave.
// Assumes clock inputs from pins are synchronous to mclk_i.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module lucal_top (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic host_hardware_sel_i,
  input wire logic board_test_tristate_n_i,
  input wire logic mute_on_signal_loss_en_i,
  input wire logic [2:0] tx_clock_in_i,
  input wire logic [2:0] reference_clock_in_i,
  input wire logic [2:0] recovered_clock_in_i,
  input wire logic [2:0] monitor_tip_in_i,
  input wire logic [2:0] monitor_ring_in_i,
  input wire logic [2:0] all_ones_tx_sel_i,
  input wire logic [2:0] signal_loss_threshold_sel_i,
  input wire logic [2:0] local_loop_sel_i,
  input wire logic [2:0] remote_loop_sel_i,
  input wire logic [2:0] rx_pos_raw_i,
  input wire logic [2:0] rx_neg_raw_i,
  input wire logic [2:0] code_err_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_o,
  output logic [2:0] tx_tip_line_o,
  output logic [2:0] tx_ring_line_o,
  output logic [2:0] all_ones_active_o,
  output logic [2:0] rx_positive_data_o,
  output logic [2:0] rx_negative_data_o,
  output logic [2:0] drive_fail_flag_o,
  output logic [2:0] rx_signal_loss_flag_o,
  output logic [2:0] rx_lock_loss_flag_o,
  output logic [2:0] code_violation_pulse_o,
  output logic [5:0] loop_mode_o,
  output logic outputs_oe_o
);
  localparam int unsigned N = lucal_pkg::NUM_CH;
  localparam int unsigned EW = lucal_pkg::EV_W;

  logic [2:0] tx_clk_d, ref_clk_d, rx_clk_d;
  logic [2:0] mark_phase;
  logic [2:0] e3_mode;
  logic [EW-1:0] irq_status, irq_mask;
  logic [2:0] drv_w, los_w, lol_w, cv_w;
  lucal_pkg::lucal_alarm_t [2:0] alarm_prev;

  // Clock edge pulses from pin-level clocks
  wire [2:0] tx_tick = tx_clock_in_i & ~tx_clk_d;
  wire [2:0] ref_tick = reference_clock_in_i & ~ref_clk_d;
  wire [2:0] rx_tick = recovered_clock_in_i & ~rx_clk_d;
  wire [2:0] rx_mark = rx_pos_raw_i | rx_neg_raw_i;

  wire hw_mode = ~host_hardware_sel_i;
  wire [2:0] aos_en = all_ones_tx_sel_i & {N{hw_mode}};
  wire mute_en = mute_on_signal_loss_en_i & hw_mode;
  wire [2:0] mute = los_w & {N{mute_en}};

  // APB decode
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire hit_ctrl = paddr == lucal_pkg::ADDR_CTRL;
  wire hit_stat = paddr == lucal_pkg::ADDR_STAT;
  wire hit_ist = paddr == lucal_pkg::ADDR_IRQ_ST;
  wire hit_msk = paddr == lucal_pkg::ADDR_IRQ_MASK;
  wire hit_any = hit_ctrl || hit_stat || hit_ist || hit_msk;
  wire [EW-1:0] live_stat = {cv_w[2], lol_w[2], los_w[2], drv_w[2],
                             cv_w[1], lol_w[1], los_w[1], drv_w[1],
                             cv_w[0], lol_w[0], los_w[0], drv_w[0]};
  wire [EW-1:0] events = live_stat & ~{alarm_prev[2], alarm_prev[1],
                                       alarm_prev[0]};
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, e3_mode} :
                       hit_stat ? {20'h0, live_stat} :
                       hit_ist ? {20'h0, irq_status} :
                       hit_msk ? {20'h0, irq_mask} : 32'h0;
  wire [EW-1:0] w1c = (apb_wr && hit_ist) ? pwdata[EW-1:0] : '0;

  // One drive and one receive monitor per channel
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      lucal_drv_mon u_drv (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .tx_tick_i(tx_tick[g]),
        .monitor_tip_in_i(monitor_tip_in_i[g]),
        .monitor_ring_in_i(monitor_ring_in_i[g]),
        .drive_fail_flag_o(drv_w[g])
      );
      lucal_rx_mon u_rx (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .rx_tick_i(rx_tick[g]),
        .ref_tick_i(ref_tick[g]),
        .rx_mark_i(rx_mark[g]),
        .code_err_i(code_err_i[g]),
        .e3_mode_i(e3_mode[g]),
        .threshold_sel_i(signal_loss_threshold_sel_i[g]),
        .signal_loss_o(los_w[g]),
        .lock_loss_o(lol_w[g]),
        .violation_o(cv_w[g])
      );
    end
  endgenerate

  // Pin clock delays for edge detection
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_clk_d <= '0;
      ref_clk_d <= '0;
      rx_clk_d <= '0;
    end else begin
      tx_clk_d <= tx_clock_in_i;
      ref_clk_d <= reference_clock_in_i;
      rx_clk_d <= recovered_clock_in_i;
    end
  end

  // Alarm levels of the previous cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      alarm_prev <= '0;
    else
      alarm_prev <= live_stat;
  end

  // Mark phase steps per tx clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      mark_phase <= '0;
    else
      mark_phase <= mark_phase ^ (tx_tick & aos_en);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_tip_line_o <= '0;
      tx_ring_line_o <= '0;
      all_ones_active_o <= '0;
    end else begin
      tx_tip_line_o <= aos_en & ~mark_phase;
      tx_ring_line_o <= aos_en & mark_phase;
      all_ones_active_o <= aos_en;
    end
  end

  function automatic logic [1:0] loop_dec(input logic l, input logic r);
    lucal_pkg::lucal_loop_t m;
    m = lucal_pkg::LUCAL_LOOP_NONE;
    case ({l, r})
      2'b10: m = lucal_pkg::LUCAL_LOOP_ANALOG_LOCAL;
      2'b01: m = lucal_pkg::LUCAL_LOOP_REMOTE;
      2'b11: m = lucal_pkg::LUCAL_LOOP_DIGITAL_LOCAL;
      default: m = lucal_pkg::LUCAL_LOOP_NONE;
    endcase
    return m;
  endfunction

  wire [2:0] ll = local_loop_sel_i & {N{hw_mode}};
  wire [2:0] rl = remote_loop_sel_i & {N{hw_mode}};
  wire [5:0] next_loop = {loop_dec(ll[2], rl[2]), loop_dec(ll[1], rl[1]),
                          loop_dec(ll[0], rl[0])};

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      outputs_oe_o <= 1'b0;
    else
      outputs_oe_o <= board_test_tristate_n_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      loop_mode_o <= '0;
    else
      loop_mode_o <= next_loop;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_positive_data_o <= '0;
      rx_negative_data_o <= '0;
    end else begin
      rx_positive_data_o <= rx_pos_raw_i & ~mute;
      rx_negative_data_o <= rx_neg_raw_i & ~mute;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      drive_fail_flag_o <= '0;
    else
      drive_fail_flag_o <= drv_w;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      rx_signal_loss_flag_o <= '0;
    else
      rx_signal_loss_flag_o <= los_w;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      rx_lock_loss_flag_o <= '0;
    else
      rx_lock_loss_flag_o <= lol_w;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      code_violation_pulse_o <= '0;
    else
      code_violation_pulse_o <= cv_w;
  end

  // APB decode of the setup cycle
  wire apb_setup = psel && !penable;
  wire apb_rd_setup = apb_setup && !pwrite;

  // Sticky status; set wins over clear
  wire [EW-1:0] next_status = (irq_status & ~w1c) | events;

  // Mask bit set blocks its status bit
  wire next_irq = |(next_status & ~irq_mask);

  // Event status register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      irq_status <= '0;
    else
      irq_status <= next_status;
  end

  // Level interrupt output
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= next_irq;
  end

  // Rate mode control register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      e3_mode <= 3'(lucal_pkg::CTRL_RST_VAL);
    else if (apb_wr && hit_ctrl)
      e3_mode <= pwdata[lucal_pkg::CTRL_E3_LSB +: 3];
  end

  // Interrupt mask register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      irq_mask <= '0;
    else if (apb_wr && hit_msk)
      irq_mask <= pwdata[EW-1:0];
  end

  // Answer one cycle after setup
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !hit_any;
      prdata <= apb_rd_setup ? rd_mux : 32'h0;
    end
  end
endmodule // lucal_top

// File: test/lucal_props.sv
// Port checker for lucal_top.
// Assumes a bind to lucal_top; one clock domain, mclk_i.
`timescale 1ns/1ns
module lucal_props (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic host_hardware_sel_i,
  input wire logic board_test_tristate_n_i,
  input wire logic [2:0] all_ones_tx_sel_i,
  input wire logic [2:0] local_loop_sel_i,
  input wire logic [2:0] remote_loop_sel_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [2:0] tx_tip_line_o,
  input wire logic [2:0] tx_ring_line_o,
  input wire logic [2:0] all_ones_active_o,
  input wire logic [2:0] code_violation_pulse_o,
  input wire logic [5:0] loop_mode_o,
  input wire logic outputs_oe_o
);
  logic [5:0] sel_code;
  assign sel_code = {remote_loop_sel_i[2], local_loop_sel_i[2],
    remote_loop_sel_i[1], local_loop_sel_i[1],
    remote_loop_sel_i[0], local_loop_sel_i[0]};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_hw_ones;
    (!host_hardware_sel_i && all_ones_tx_sel_i[0]) [*3];
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_OE_OFF: assert property (
    !board_test_tristate_n_i |=> !outputs_oe_o)
    else $error("outputs enabled in test");
  AST_OE_ON: assert property (
    board_test_tristate_n_i [*2] |=> outputs_oe_o)
    else $error("outputs off in normal run");
  AST_LOOP_HW: assert property (!host_hardware_sel_i |=>
    loop_mode_o == $past(sel_code)) else $error("loop decode wrong");
  AST_LOOP_HOST: assert property (
    host_hardware_sel_i |=> !loop_mode_o)
    else $error("loop active in host mode");
  AST_AO_HOST: assert property (
    host_hardware_sel_i [*2] |-> !all_ones_active_o)
    else $error("all ones in host mode");
  AST_AO_HW: assert property (s_hw_ones |-> all_ones_active_o[0])
    else $error("all ones not sent");
  AST_AMI: assert property (all_ones_active_o[0] |->
    (tx_tip_line_o[0] ^ tx_ring_line_o[0])) else $error("one rail per mark");
  AST_VIOL: assert property (
    (code_violation_pulse_o & $past(code_violation_pulse_o)) == 3'h0)
    else $error("violation pulse too long");
endmodule // lucal_props

// File: test/lucal_far_end.sv
// Far-end model: line clocks, receive stream, violation tally.
// Assumes mclk_i at 100 MHz; outputs change after its rising edge.
`timescale 1ns/1ns
module lucal_far_end (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic slow_i,
  input wire logic silent_i,
  input wire logic err_i,
  input wire logic viol_i,
  output logic clk_o,
  output logic rec_o,
  output logic pos_o,
  output logic neg_o,
  output logic err_o,
  output logic [7:0] err_n_o,
  output logic [7:0] viol_n_o
);
  logic half;
  logic [1:0] rdiv;
  logic [1:0] lim;
  logic rise;
  // Slow mode stretches the recovered clock
  assign lim = slow_i ? 2'h2 : 2'h1;
  assign rise = !rec_o && rdiv == lim;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      half <= 1'b0;
      clk_o <= 1'b0;
      rdiv <= 2'h0;
      rec_o <= 1'b0;
      pos_o <= 1'b0;
      neg_o <= 1'b0;
      err_o <= 1'b0;
      err_n_o <= 8'h00;
      viol_n_o <= 8'h00;
    end else begin
      half <= !half;
      clk_o <= half ? !clk_o : clk_o;
      rdiv <= (rdiv == lim) ? 2'h0 : rdiv + 2'h1;
      rec_o <= (rdiv == lim) ? !rec_o : rec_o;
      viol_n_o <= viol_n_o + 8'(viol_i);
      if (rise) begin
        pos_o <= !silent_i && !pos_o;
        neg_o <= !silent_i && pos_o;
        err_o <= err_i;
        err_n_o <= err_n_o + 8'(err_i);
      end
    end
  end
endmodule // lucal_far_end

// File: test/lucal_tb_top.sv
// Self-checking bench for lucal_top with far-end model and checker.
// Assumes 100 MHz mclk_i and zero-wait APB answers.
`timescale 1ns/1ns
module lucal_tb_top;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, hs = 1'b0, tn = 1'b1;
  logic mute = 1'b1, slow = 1'b0, silent = 1'b0, err = 1'b0;
  logic [2:0] ao_sel = 3'h0, lsel = 3'h0, rsel = 3'h0, mon_on = 3'h7;
  logic [2:0] thr = 3'h2;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tclk, rec, pos, neg, cerr, pready, pslverr, irq, oe;
  logic [7:0] en, vn;
  logic [31:0] prdata;
  logic [2:0] tip, ring, aoa, rx_positive_data, rx_negative_data, df, los, lol, cv;
  logic [5:0] lm;
  int failures = 0;
  int tests_run = 0;
  always #5 mclk_i = ~mclk_i;
  lucal_top u_lucal_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .host_hardware_sel_i(hs), .board_test_tristate_n_i(tn),
    .mute_on_signal_loss_en_i(mute), .tx_clock_in_i({3{tclk}}),
    .reference_clock_in_i({3{tclk}}), .recovered_clock_in_i({3{rec}}),
    .monitor_tip_in_i(mon_on & {3{tclk}}), .monitor_ring_in_i(3'h0),
    .all_ones_tx_sel_i(ao_sel), .signal_loss_threshold_sel_i(thr),
    .local_loop_sel_i(lsel), .remote_loop_sel_i(rsel),
    .rx_pos_raw_i({3{pos}}), .rx_neg_raw_i({3{neg}}),
    .code_err_i({3{cerr}}), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_o(irq),
    .tx_tip_line_o(tip), .tx_ring_line_o(ring), .all_ones_active_o(aoa),
    .rx_positive_data_o(rx_positive_data), .rx_negative_data_o(rx_negative_data),
    .drive_fail_flag_o(df), .rx_signal_loss_flag_o(los),
    .rx_lock_loss_flag_o(lol), .code_violation_pulse_o(cv),
    .loop_mode_o(lm), .outputs_oe_o(oe));
  lucal_far_end u_lucal_far_end (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .slow_i(slow), .silent_i(silent), .err_i(err), .viol_i(cv[0]),
    .clk_o(tclk), .rec_o(rec), .pos_o(pos), .neg_o(neg), .err_o(cerr),
    .err_n_o(en), .viol_n_o(vn));
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(60000);
    failures++;
    $display("BAD watchdog expected done seen hang");
    test_done();
  end
  initial begin
    logic [31:0] q;
    logic e, pt, pr;
    logic [2:0] pl;
    int nt, nr, bad;
    cyc(8);
    sys_rst_i <= 1'b0;
    rd(lucal_pkg::ADDR_CTRL, 32'h0, "ctrl_reset");
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped_err", 32'h1, 32'(e));
    chk("unmapped_data", 32'h0, q);
    wr(lucal_pkg::ADDR_CTRL, 32'h4);
    rd(lucal_pkg::ADDR_CTRL, 32'h4, "ctrl");
    $display("apb done");
    for (int v = 0; v < 4; v++) begin
      lsel <= {3{v[0]}};
      rsel <= {3{v[1]}};
      cyc(3);
      chk("loop", 32'({3{v[1:0]}}), 32'(lm));
    end
    hs <= 1'b1;
    ao_sel <= 3'h7;
    cyc(3);
    chk("loop_host", 32'h0, 32'(lm));
    chk("ao_host", 32'h0, 32'(aoa));
    hs <= 1'b0;
    lsel <= 3'h0;
    rsel <= 3'h0;
    ao_sel <= 3'h1;
    cyc(4);
    chk("ao_on", 32'h1, 32'(aoa));
    nt = 0;
    nr = 0;
    pt = 1'b0;
    pr = 1'b0;
    repeat (64) begin
      @(posedge mclk_i);
      nt += int'(tip[0] && !pt);
      nr += int'(ring[0] && !pr);
      pt = tip[0];
      pr = ring[0];
    end
    chk("ao_marks", 32'h1,
      32'(nt inside {[7:9]} && nr inside {[7:9]}));
    ao_sel <= 3'h0;
    $display("loop and all ones done");
    mon_on <= 3'h6;
    cyc(360);
    chk("drv_early", 32'h0, 32'(df));
    cyc(300);
    chk("drv_late", 32'h1, 32'(df));
    mon_on <= 3'h7;
    cyc(10);
    chk("drv_clear", 32'h0, 32'(df));
    tn <= 1'b0;
    cyc(2);
    chk("oe_off", 32'h0, 32'(oe));
    tn <= 1'b1;
    cyc(2);
    chk("oe_on", 32'h1, 32'(oe));
    wr(lucal_pkg::ADDR_IRQ_ST, 32'hFFF);
    $display("drive and test input done");
    silent <= 1'b1;
    cyc(160);
    chk("los_e3", 32'h4, 32'(los));
    cyc(400);
    chk("los_sel_hi", 32'h6, 32'(los));
    cyc(240);
    chk("los_sel_lo", 32'h7, 32'(los));
    rd(lucal_pkg::ADDR_IRQ_ST, 32'h222, "irq_status");
    wr(lucal_pkg::ADDR_IRQ_MASK, 32'hFFF);
    cyc(2);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(lucal_pkg::ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq_open", 32'h1, 32'(irq));
    wr(lucal_pkg::ADDR_IRQ_ST, 32'h222);
    rd(lucal_pkg::ADDR_IRQ_ST, 32'h0, "irq_cleared");
    chk("irq_low", 32'h0, 32'(irq));
    silent <= 1'b0;
    bad = 0;
    pl = los;
    repeat (40) begin
      @(posedge mclk_i);
      bad += int'(|(los & pl & (rx_positive_data | rx_negative_data)));
      pl = los;
    end
    chk("mute", 32'h0, 32'(bad));
    // Mute off, then mute on in host mode: data pass
    for (int k = 0; k < 2; k++) begin
      mute <= (k == 1);
      hs <= (k == 1);
      silent <= 1'b1;
      cyc(160);
      silent <= 1'b0;
      bad = 0;
      repeat (40) begin
        @(posedge mclk_i);
        bad += int'(los[2] && (rx_positive_data[2] || rx_negative_data[2]));
      end
      chk("mute_off", 32'h1, 32'(bad > 0));
    end
    hs <= 1'b0;
    mute <= 1'b1;
    $display("signal loss done");
    err <= 1'b1;
    cyc(22);
    err <= 1'b0;
    cyc(10);
    chk("viol_count", 32'(en), 32'(vn));
    slow <= 1'b1;
    cyc(10000);
    chk("lock_lost", 32'h7, 32'(lol));
    slow <= 1'b0;
    cyc(10000);
    chk("lock_back", 32'h0, 32'(lol));
    $display("violation and lock done");
    test_done();
  end
endmodule // lucal_tb_top
bind lucal_top lucal_props u_lucal_props (.mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i), .host_hardware_sel_i(host_hardware_sel_i),
  .board_test_tristate_n_i(board_test_tristate_n_i),
  .all_ones_tx_sel_i(all_ones_tx_sel_i),
  .local_loop_sel_i(local_loop_sel_i),
  .remote_loop_sel_i(remote_loop_sel_i), .psel(psel),
  .penable(penable), .pready(pready), .tx_tip_line_o(tx_tip_line_o),
  .tx_ring_line_o(tx_ring_line_o), .all_ones_active_o(all_ones_active_o),
  .code_violation_pulse_o(code_violation_pulse_o),
  .loop_mode_o(loop_mode_o), .outputs_oe_o(outputs_oe_o));
